// ===== tb/rft_reader.sv
// reader model: sends request frames, collects and checks answers
// assumes the tag samples the link lines with its own clock
`timescale 1ns/1ps
module rft_reader (
  output logic      lnk_clk, // link clock, runs only in exchanges
  output logic      rx_frm,  // request framing level
  output logic      rx_dat,  // request bit
  input  wire logic tx_frm,  // tag answering
  input  wire logic tx_dat   // tag bit
);
  logic [7:0] rq [0:31];
  logic [7:0] rs [0:31];
  int         rq_n;
  int         rs_n;
  int         rs_b;
  logic       bad_crc;
  logic       rs_crc_ok;
  int         xbits; // extra bits after the crc, a cut byte

  initial
  begin
    lnk_clk = 1'b0;
    rx_frm = 1'b0;
    rx_dat = 1'b0;
    bad_crc = 1'b0;
    rs_n = 0;
    rs_crc_ok = 1'b0;
    xbits = 0;
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
    return r;
  endfunction

  task send;
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < rq_n; i++)
      c = crc_step(c, rq[i]);
    c = ~c ^ {15'h0, bad_crc};
    rq[rq_n] = c[7:0];
    rq[rq_n + 1] = c[15:8];
    rq[rq_n + 2] = 8'hA5;
    // off-grid timing keeps the tag's samplers away from races
    #1.1 rx_frm = 1'b1;
    for (int i = 0; i < 8 * (rq_n + 2) + xbits; i++)
    begin
      rx_dat = rq[i / 8][i % 8];
      #31.3 lnk_clk = 1'b1;
      #62.5 lnk_clk = 1'b0;
      #31.2;
    end
    rx_frm = 1'b0;
    rx_dat = ~rx_dat;
  endtask

  task listen(input int nb);
    logic        fr;
    logic [15:0] c;
    rs_b = 0;
    for (int i = 0; i < nb; i++)
    begin
      #31.3 lnk_clk = 1'b1;
      fr = tx_frm;
      #62.5 lnk_clk = 1'b0;
      // the tag drops its frame level together with the last bit,
      // so only the level seen at the rise decides
      if (fr && rs_b < 256)
      begin
        rs[rs_b / 8][rs_b % 8] = tx_dat;
        rs_b++;
      end
      #31.2;
    end
    rs_n = rs_b / 8;
    c = 16'hFFFF;
    for (int i = 0; i + 2 < rs_n; i++)
      c = crc_step(c, rs[i]);
    rs_crc_ok = (rs_n > 2) && (rs_b % 8 == 0) &&
                (~c === {rs[rs_n - 1], rs[rs_n - 2]});
  endtask
endmodule // rft_reader

// ===== tb/tb.sv
// self-checking bench of the tag frame logic
// assumes the reader model drives the link, this module the ahb side
`timescale 1ns/1ps
module tb;
  localparam logic [63:0] UID = 64'hC33C_1122_3344_5566; // arbitrary
  logic        mclk     = 1'b0;
  logic        rstn     = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [2:0]  hsize    = 3'h2;
  logic        field_ok = 1'b0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic        lnk_clk, rx_frm, rx_dat, tx_frm, tx_dat;
  int          err_total = 0;
  int          checks_done = 0;

  always #2 mclk = ~mclk;

  rft_frame #(.UID_CLASS(UID[63:56]), .UID_MAKER(UID[55:48]),
              .UID_SERIAL(UID[47:0])) dut_u (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .field_ok(field_ok), .lnk_clk(lnk_clk), .rx_frm(rx_frm),
    .rx_dat(rx_dat), .tx_frm(tx_frm), .tx_dat(tx_dat));

  rft_reader rdr_u (.lnk_clk(lnk_clk), .rx_frm(rx_frm), .rx_dat(rx_dat),
                    .tx_frm(tx_frm), .tx_dat(tx_dat));

  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task rdy_edge;
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      conclude;
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy_edge;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_edge;
    r = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
           input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, r & m, e);
    chk("response", hresp, 32'h0);
  endtask

  task req(input logic [7:0] fl, input logic [63:0] uid, input logic bad,
           input int nb, input logic pend);
    int n;
    rdr_u.rq[0] = fl;
    rdr_u.rq[1] = 8'h20;
    n = 2;
    if (fl[rft_pkg::RQ_ADR_BIT] && !fl[rft_pkg::RQ_INV_BIT])
      for (int i = 0; i < 8; i++)
      begin
        rdr_u.rq[n] = uid[8 * i +: 8];
        n++;
      end
    rdr_u.rq[n] = 8'h5E;
    rdr_u.rq_n = n + 1;
    rdr_u.bad_crc = bad;
    rdr_u.send;
    rdr_u.listen(40);
    @(posedge mclk);
    chk("answer bytes", rdr_u.rs_n, nb);
    if (nb == 0)
      rdc("pending", rft_pkg::OFS_STATUS, 32'h4, {29'h0, pend, 2'h0});
  endtask

  task answer(input int len, input logic [1:0] st);
    logic [31:0] c;
    for (int i = 0; i < len; i++)
      wr(rft_pkg::OFS_TX_BUF + 8'(4 * i), 32'hC0 + i);
    c = 32'h0;
    c[4:0] = len[4:0];
    c[25:24] = st;
    c[rft_pkg::TXC_SVAL_BIT] = 1'b1;
    c[rft_pkg::TXC_GO_BIT] = 1'b1;
    fork
      rdr_u.listen(8 * len + 40);
      wr(rft_pkg::OFS_TX_CTRL, c);
    join
    @(posedge mclk);
    chk("answer bytes", rdr_u.rs_n, len + 3);
    chk("answer flags", rdr_u.rs[0], rft_pkg::RSP_OK_FLG);
    for (int i = 0; i < len; i++)
      chk("answer data", rdr_u.rs[i + 1], 32'hC0 + i);
    chk("answer crc", rdr_u.rs_crc_ok, 1'b1);
    rdc("status", rft_pkg::OFS_STATUS, 32'hF, {30'h0, st});
  endtask

  task t_reset;
    rdc("state off", rft_pkg::OFS_STATUS, 32'h3, rft_pkg::ST_OFF);
    rdr_u.listen(16);
    @(posedge mclk);
    chk("idle answer", rdr_u.rs_n, 0);
    field_ok <= 1'b1;
    repeat (10) @(posedge mclk);
    rdc("state on", rft_pkg::OFS_STATUS, 32'h3, rft_pkg::ST_READY);
    rdc("uid low", rft_pkg::OFS_UID_LO, 32'hFFFFFFFF, UID[31:0]);
    rdc("uid high", rft_pkg::OFS_UID_HI, 32'hFFFFFFFF, UID[63:32]);
    wr(rft_pkg::OFS_UID_LO, 32'h0);
    rdc("uid kept", rft_pkg::OFS_UID_LO, 32'hFFFFFFFF, UID[31:0]);
    rdc("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
  endtask

  task t_ids;
    wr(rft_pkg::OFS_AFI, 32'h3B);
    rdc("afi", rft_pkg::OFS_AFI, 32'h3EFF, 32'h263B);
    wr(rft_pkg::OFS_AFI, 32'h140);
    wr(rft_pkg::OFS_AFI, 32'h77);
    rdc("afi lock", rft_pkg::OFS_AFI, 32'h3EFF, 32'h840);
    rdc("afi flags", rft_pkg::OFS_STATUS, 32'h50, 32'h50);
    wr(rft_pkg::OFS_DSFID, 32'h11);
    rdc("dsfid", rft_pkg::OFS_DSFID, 32'hFF, 32'h11);
    wr(rft_pkg::OFS_DSFID, 32'h122);
    wr(rft_pkg::OFS_DSFID, 32'h33);
    rdc("dsfid lock", rft_pkg::OFS_DSFID, 32'hFF, 32'h22);
    rdc("dsfid flags", rft_pkg::OFS_STATUS, 32'hA0, 32'hA0);
    $display("test ids done");
  endtask

  task t_modes;
    rdr_u.xbits = 3;
    req(8'h02, UID, 1'b0, 0, 1'b0);
    rdr_u.xbits = 0;
    req(8'h02, UID, 1'b1, 0, 1'b0);
    req(8'h02, UID, 1'b0, 0, 1'b1);
    rdc("command", rft_pkg::OFS_RX_INFO, 32'h1FF1F, 32'h12005);
    rdc("rx command", rft_pkg::OFS_RX_BUF + 8'h04, 32'hFF, 32'h20);
    answer(2, rft_pkg::ST_READY);
    req(8'h12, UID, 1'b0, 0, 1'b0);
    req(8'h22, UID ^ 64'h1, 1'b0, 0, 1'b0);
    req(8'h22, UID, 1'b0, 0, 1'b1);
    answer(0, rft_pkg::ST_QUIET);
    req(8'h02, UID, 1'b0, 0, 1'b0);
    req(8'h12, UID, 1'b0, 0, 1'b0);
    req(8'h06, UID, 1'b0, 0, 1'b0);
    req(8'h22, UID, 1'b0, 0, 1'b1);
    answer(1, rft_pkg::ST_SELECTED);
    req(8'h12, UID, 1'b0, 0, 1'b1);
    req(8'h26, UID, 1'b0, 0, 1'b1);
    req(8'h02, UID, 1'b0, 0, 1'b1);
    req(8'h32, UID, 1'b0, 4, 1'b0);
    chk("error flags", rdr_u.rs[0], rft_pkg::RSP_ERR_FLG);
    chk("error code", rdr_u.rs[1], rft_pkg::ERR_OPTION);
    chk("error crc", rdr_u.rs_crc_ok, 1'b1);
    $display("test modes done");
  endtask

  task t_field;
    field_ok <= 1'b0;
    repeat (10) @(posedge mclk);
    rdc("field lost", rft_pkg::OFS_STATUS, 32'h3, rft_pkg::ST_OFF);
    field_ok <= 1'b1;
    repeat (10) @(posedge mclk);
    rdc("field back", rft_pkg::OFS_STATUS, 32'h3, rft_pkg::ST_READY);
    $display("test field done");
  endtask

  initial
  begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_ids;
    t_modes;
    t_field;
    conclude;
  end
endmodule // tb

// ===== verilog/rft_frame.sv
// tag frame logic: rx framing and crc, answer decision, tx framing, regs
// assumes a demodulator giving bits on a link clock and a framing level,
// and a modulator taking bits on the same link clock
`timescale 1ns/1ps
module rft_frame #(
  parameter logic [7:0]  UID_CLASS  = 8'hA5, // arbitrary value
  parameter logic [7:0]  UID_MAKER  = 8'h5A, // arbitrary value
  parameter logic [47:0] UID_SERIAL = 48'h0123_4567_89AB
) (
  input  wire logic        mclk,      // 250 mhz system clock
  input  wire logic        rstn,      // async reset, active low
  input  wire logic        hsel,      // ahb slave select
  input  wire logic [31:0] haddr,     // ahb address
  input  wire logic [1:0]  htrans,    // ahb transfer type
  input  wire logic        hwrite,    // ahb write
  input  wire logic [2:0]  hsize,     // ahb size, word only
  input  wire logic [31:0] hwdata,    // ahb write data
  input  wire logic        hready,    // ahb bus ready
  output logic             hreadyout, // ahb slave ready
  output logic      [31:0] hrdata,    // ahb read data
  output logic             hresp,     // ahb response, always okay
  input  wire logic        field_ok,  // enough field energy
  input  wire logic        lnk_clk,   // recovered bit clock
  input  wire logic        rx_frm,    // high between sof and eof
  input  wire logic        rx_dat,    // received bit
  output logic             tx_frm,    // high while answering
  output logic             tx_dat     // transmitted bit
);
  localparam logic [63:0] UID = {UID_CLASS, UID_MAKER, UID_SERIAL};

  // three-stage sync, a level changes once stages 2 and 3 agree
  logic [3:0] pin_in, s1_q, s2_q, s3_q, flt_q;
  assign pin_in = {field_ok, lnk_clk, rx_frm, rx_dat};
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_sync
      always_ff @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
        begin
          s1_q[g]  <= 1'b0;
          s2_q[g]  <= 1'b0;
          s3_q[g]  <= 1'b0;
          flt_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
            flt_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  logic fld, lclk, frm, dat, lclk_q, frm_q, fld_q, ledge, frm_end;
  assign {fld, lclk, frm, dat} = flt_q;
  assign ledge   = lclk & ~lclk_q;
  assign frm_end = frm_q & ~frm;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lclk_q <= 1'b0;
      frm_q  <= 1'b0;
      fld_q  <= 1'b0;
    end
    else
    begin
      lclk_q <= lclk;
      frm_q  <= frm;
      fld_q  <= fld;
    end
  end

  // receive: lsb first, one byte per eight edges, crc runs per byte
  logic [7:0]  rx_mem [rft_pkg::BUF_BYTES];
  logic [7:0]  sh_q;
  logic [2:0]  bit_q;
  logic [4:0]  nb_q;
  logic        ovf_q;
  logic [15:0] rcrc_q;
  logic        tx_busy;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_q   <= 8'h00;
      bit_q  <= 3'h0;
      nb_q   <= 5'h00;
      ovf_q  <= 1'b0;
      rcrc_q <= rft_pkg::CRC_PRESET;
    end
    else if (frm && !frm_q)
    begin
      bit_q  <= 3'h0;
      nb_q   <= 5'h00;
      ovf_q  <= 1'b0;
      rcrc_q <= rft_pkg::CRC_PRESET;
    end
    else if (frm && ledge && !tx_busy)
    begin
      sh_q  <= {dat, sh_q[7:1]};
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7)
      begin
        rcrc_q <= rft_pkg::crc_byte(rcrc_q, {dat, sh_q[7:1]});
        if (nb_q == 5'(rft_pkg::BUF_BYTES))
          ovf_q <= 1'b1;
        else
          nb_q <= nb_q + 5'h01;
      end
    end
  end
  always_ff @(posedge mclk)
  begin
    if (frm && ledge && !tx_busy && bit_q == 3'h7 && !nb_q[4])
      rx_mem[nb_q[3:0]] <= {dat, sh_q[7:1]};
  end

  // decision at frame end
  rft_pkg::rft_state_t st_q;
  rft_pkg::rft_rqflags_t rq;
  logic good, uid_ok, ans, err03;
  assign rq.inv = rx_mem[0][rft_pkg::RQ_INV_BIT];
  assign rq.sel = !rq.inv && rx_mem[0][rft_pkg::RQ_SEL_BIT];
  assign rq.adr = !rq.inv && rx_mem[0][rft_pkg::RQ_ADR_BIT];
  assign good = bit_q == 3'h0 && !ovf_q && nb_q >= 5'(rft_pkg::MIN_REQ)
             && rcrc_q == rft_pkg::CRC_RESIDUE;
  assign uid_ok = nb_q >= 5'(rft_pkg::MIN_REQ + 8) &&
    {rx_mem[9], rx_mem[8], rx_mem[7], rx_mem[6],
     rx_mem[5], rx_mem[4], rx_mem[3], rx_mem[2]} == UID;
  assign err03 = rq.adr && rq.sel;
  always_comb
  begin
    ans = 1'b0;
    if (st_q != rft_pkg::ST_OFF)
    begin
      if (rq.adr)
        ans = uid_ok;
      else if (rq.sel)
        ans = st_q == rft_pkg::ST_SELECTED;
      else
        ans = st_q != rft_pkg::ST_QUIET;
    end
  end

  logic       acc, pend_q, last_ok_q;
  logic [4:0] last_nb_q;
  assign acc = frm_end && good && (ans || err03);
  rft_pkg::rft_txcmd_t txc;
  logic       go_sw, go, aerr_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_q    <= 1'b0;
      last_ok_q <= 1'b0;
      last_nb_q <= 5'h00;
      aerr_q    <= 1'b0;
    end
    else
    begin
      if (frm_end)
      begin
        last_ok_q <= acc;
        last_nb_q <= nb_q;
      end
      if (acc && !err03)
        pend_q <= 1'b1;
      else if (go || (frm && !frm_q) || !fld)
        pend_q <= 1'b0;
      aerr_q <= acc && err03;
    end
  end

  // tag state; software moves between ready, quiet, selected
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      st_q <= rft_pkg::ST_OFF;
    else if (!fld)
      st_q <= rft_pkg::ST_OFF;
    else if (!fld_q)
      st_q <= rft_pkg::ST_READY;
    else if (go_sw && txc.valid)
      st_q <= rft_pkg::rft_state_t'(txc.state == 2'h0 ? 2'h1 : txc.state);
  end

  // transmit: flags, optional error code, data, crc low then high
  logic [7:0]  tx_mem [rft_pkg::BUF_BYTES];
  logic [5:0]  tpos_q, tlast_q;
  logic [2:0]  tbit_q;
  logic        terr_q;
  logic [7:0]  tcode_q, tbyte;
  logic [15:0] tcrc_q;
  logic [4:0]  dix;
  assign go = go_sw || aerr_q;
  assign tx_busy = tx_frm;
  always_comb
  begin
    dix = 5'(tpos_q - 6'(1 + terr_q));
    if (tpos_q == 6'h00)
      tbyte = terr_q ? rft_pkg::RSP_ERR_FLG : rft_pkg::RSP_OK_FLG;
    else if (terr_q && tpos_q == 6'h01)
      tbyte = tcode_q;
    else if (tpos_q == tlast_q - 6'h01)
      tbyte = ~tcrc_q[7:0];
    else if (tpos_q == tlast_q)
      tbyte = ~tcrc_q[15:8];
    else
      tbyte = tx_mem[dix[3:0]];
  end
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_frm  <= 1'b0;
      tx_dat  <= 1'b0;
      tpos_q  <= 6'h00;
      tlast_q <= 6'h00;
      tbit_q  <= 3'h0;
      terr_q  <= 1'b0;
      tcode_q <= 8'h00;
      tcrc_q  <= rft_pkg::CRC_PRESET;
    end
    else if (!fld)
      tx_frm <= 1'b0;
    else if (go && !tx_frm)
    begin
      tx_frm  <= 1'b1;
      tpos_q  <= 6'h00;
      tbit_q  <= 3'h0;
      tcrc_q  <= rft_pkg::CRC_PRESET;
      terr_q  <= aerr_q ? 1'b1 : txc.err;
      tcode_q <= aerr_q ? rft_pkg::ERR_OPTION : txc.code;
      tlast_q <= aerr_q ? 6'h03
               : 6'(txc.len) + 6'(txc.err) + 6'h02;
    end
    else if (tx_frm && ledge)
    begin
      tx_dat <= tbyte[tbit_q];
      tbit_q <= tbit_q + 3'h1;
      if (tbit_q == 3'h7)
      begin
        if (tpos_q < tlast_q - 6'h01)
          tcrc_q <= rft_pkg::crc_byte(tcrc_q, tbyte);
        if (tpos_q == tlast_q)
          tx_frm <= 1'b0;
        tpos_q <= tpos_q + 6'h01;
      end
    end
  end

  // ahb-lite slave, zero wait, data registered in address phase
  logic        ap_wr_q;
  logic [7:0]  ap_ofs_q;
  logic [7:0]  afi_q, dsfid_q;
  logic        afi_lk_q, dsfid_lk_q, afi_rfs_q, dsfid_rfs_q;
  logic        ap_rd;
  logic [31:0] rd_d;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_rd = hsel && hready && htrans[1] && !hwrite;
  assign txc.valid = hwdata[rft_pkg::TXC_SVAL_BIT];
  assign txc.state = hwdata[25:24];
  assign txc.len   = hwdata[4:0];
  assign txc.err   = hwdata[rft_pkg::TXC_ERR_BIT];
  assign txc.code  = hwdata[23:16];
  assign go_sw = ap_wr_q && ap_ofs_q == rft_pkg::OFS_TX_CTRL
              && hwdata[rft_pkg::TXC_GO_BIT] && pend_q && !tx_frm;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ap_wr_q  <= 1'b0;
      ap_ofs_q <= 8'h00;
    end
    else if (hready)
    begin
      ap_wr_q  <= hsel && htrans[1] && hwrite;
      ap_ofs_q <= {haddr[7:2], 2'b00};
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      afi_q       <= rft_pkg::AFI_RST;
      dsfid_q     <= rft_pkg::DSFID_RST;
      afi_lk_q    <= 1'b0;
      dsfid_lk_q  <= 1'b0;
      afi_rfs_q   <= 1'b0;
      dsfid_rfs_q <= 1'b0;
    end
    else if (ap_wr_q)
    begin
      if (ap_ofs_q == rft_pkg::OFS_AFI)
      begin
        if (afi_lk_q)
          afi_rfs_q <= 1'b1;
        else
        begin
          afi_q    <= hwdata[7:0];
          afi_lk_q <= hwdata[rft_pkg::LOCK_BIT];
        end
      end
      if (ap_ofs_q == rft_pkg::OFS_DSFID)
      begin
        if (dsfid_lk_q)
          dsfid_rfs_q <= 1'b1;
        else
        begin
          dsfid_q    <= hwdata[7:0];
          dsfid_lk_q <= hwdata[rft_pkg::LOCK_BIT];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (ap_wr_q && ap_ofs_q[7] && ap_ofs_q[6:2] < 5'(rft_pkg::BUF_BYTES))
      tx_mem[ap_ofs_q[5:2]] <= hwdata[7:0];
  end

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0] & 8'hFC)
      rft_pkg::OFS_STATUS:
        rd_d = {24'h00_0000, dsfid_rfs_q, afi_rfs_q, dsfid_lk_q, afi_lk_q,
                tx_frm, pend_q, st_q};
      rft_pkg::OFS_AFI:
        rd_d = {18'h0_0000, afi_q[3:0] != 4'h0, afi_q[7:4],
                afi_lk_q, afi_q};
      rft_pkg::OFS_DSFID:
        rd_d = {23'h00_0000, dsfid_lk_q, dsfid_q};
      rft_pkg::OFS_UID_LO:
        rd_d = UID[31:0];
      rft_pkg::OFS_UID_HI:
        rd_d = UID[63:32];
      rft_pkg::OFS_RX_INFO:
        rd_d = {15'h0000, last_ok_q, rx_mem[1], 3'h0, last_nb_q};
      default:
        if (haddr[7:6] == 2'b01 && 5'(haddr[5:2]) < 5'(rft_pkg::BUF_BYTES))
          rd_d = {24'h00_0000, rx_mem[haddr[5:2]]};
        else
          rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (ap_rd)
      hrdata <= rd_d;
  end

  // checks
  sequence s_tx_start;
    !tx_frm ##1 tx_frm;
  endsequence
  sequence s_err_req;
    frm_end && good && err03 && st_q != rft_pkg::ST_OFF;
  endsequence

  a_crc_drop: assert property (@(posedge mclk) disable iff (!rstn)
    frm_end && !good |=> !pend_q ##1 !tx_frm)
    else $error("bad frame left an answer pending");
  a_talk_first: assert property (@(posedge mclk) disable iff (!rstn)
    s_tx_start |-> $past(pend_q) || $past(aerr_q))
    else $error("transmit began without a request");
  a_err_answer: assert property (@(posedge mclk) disable iff (!rstn)
    s_err_req |-> ##2 (tx_frm && terr_q && tcode_q == rft_pkg::ERR_OPTION))
    else $error("address plus select gave no error 03");
  a_afi_locked: assert property (@(posedge mclk) disable iff (!rstn)
    afi_lk_q |=> $stable(afi_q) && afi_lk_q)
    else $error("locked afi changed");
  a_dsfid_lock: assert property (@(posedge mclk) disable iff (!rstn)
    dsfid_lk_q |=> $stable(dsfid_q) && dsfid_lk_q)
    else $error("locked dsfid changed");
  a_quiet_silent: assert property (@(posedge mclk) disable iff (!rstn)
    frm_end && st_q == rft_pkg::ST_QUIET && !rq.adr |=> !pend_q)
    else $error("quiet tag accepted an unaddressed request");
  a_select_only: assert property (@(posedge mclk) disable iff (!rstn)
    frm_end && rq.sel && !rq.adr && st_q != rft_pkg::ST_SELECTED
    |=> !pend_q)
    else $error("select request accepted outside selected");
  a_field_off: assert property (@(posedge mclk) disable iff (!rstn)
    !fld |=> st_q == rft_pkg::ST_OFF && !tx_frm)
    else $error("tag active without field");
  a_whole_bytes: assert property (@(posedge mclk) disable iff (!rstn)
    frm_end && bit_q != 3'h0 |=> !pend_q && !last_ok_q)
    else $error("partial byte frame accepted");
  a_err_flag: assert property (@(posedge mclk) disable iff (!rstn)
    tx_frm && tpos_q == 6'h00 |-> tbyte[0] == terr_q)
    else $error("response error flag wrong");
endmodule // rft_frame

// ===== verilog/rft_pkg.sv
// package of the tag frame logic: register map, flag positions, crc helper
// assumes an ahb-lite master with word accesses and a sampled link clock
package rft_pkg;
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_AFI      = 8'h04;
  localparam logic [7:0]  OFS_DSFID    = 8'h08;
  localparam logic [7:0]  OFS_UID_LO   = 8'h0C;
  localparam logic [7:0]  OFS_UID_HI   = 8'h10;
  localparam logic [7:0]  OFS_RX_INFO  = 8'h14;
  localparam logic [7:0]  OFS_TX_CTRL  = 8'h18;
  localparam logic [7:0]  OFS_RX_BUF   = 8'h40;
  localparam logic [7:0]  OFS_TX_BUF   = 8'h80;
  localparam int          BUF_BYTES    = 16;
  // write-one bit that locks afi or dsfid together with the written value
  localparam int          LOCK_BIT     = 8;
  localparam int          TXC_ERR_BIT  = 8;
  localparam int          TXC_SVAL_BIT = 26;
  localparam int          TXC_GO_BIT   = 31;
  localparam logic [7:0]  AFI_RST      = 8'h00;
  localparam logic [7:0]  DSFID_RST    = 8'h00;
  localparam logic [15:0] CRC_PRESET   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE  = 16'hF0B8;
  localparam logic [7:0]  ERR_OPTION   = 8'h03;
  localparam logic [7:0]  RSP_ERR_FLG  = 8'h01;
  localparam logic [7:0]  RSP_OK_FLG   = 8'h00;
  // request flag positions, counted from zero
  localparam int          RQ_INV_BIT   = 2;
  localparam int          RQ_SEL_BIT   = 4;
  localparam int          RQ_ADR_BIT   = 5;
  localparam int          UID_FIRST    = 2;
  localparam int          MIN_REQ      = 4;

  typedef enum logic [1:0] {ST_OFF, ST_READY, ST_QUIET, ST_SELECTED}
    rft_state_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] state;
    logic [4:0] len;
    logic       err;
    logic [7:0] code;
  } rft_txcmd_t;

  typedef struct packed {
    logic inv;
    logic sel;
    logic adr;
  } rft_rqflags_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    return r;
  endfunction
endpackage
